// >>> logic/adc_sequencer.sv
// Conversion sequencer of the 10-bit converter with its APB register file
//
// What this block does
// - A conversion phase counts eleven bit-period ticks; after acquisition select 000 the first period can be partial.
// - Clock select 000/100/001/101/010/110 gives 2..64 clocks; x11 selects RC.
// - Acquisition select 010 samples four bit periods, then converts.
// - Acquisition select 000 delays conversion by one instruction cycle.
// - Clearing start/done mid-conversion aborts it and drops the partial result.
// - After an abort the result bytes keep their previous contents.
// - After completion or abort wait two bit periods, then sample again.
// - Compare mode 1011 trigger sets start/done when enabled and clears timer.
// - With converter disabled the trigger only clears the timer.
// - Port read returns zero on every pin configured as analog.
// - Sequencing ignores channel select and pin configuration bits.
// - Completion clears start/done, sets the complete flag, resumes sampling.
// - Nonzero acquisition select samples for its length, then converts.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module adc_sequencer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  pin_in,
  input  wire logic        rc_strobe,
  input  wire logic        comp_bit,
  input  wire logic        special_event,
  output logic             sample_en,
  output logic             conv_active,
  output logic             bit_strobe,
  output logic      [2:0]  channel,
  output logic             ref_pos_sel,
  output logic             ref_neg_sel,
  output logic             timer_clear,
  output logic             complete_flag
);

  typedef struct packed {
    adc_seq_pkg::seq_state_e st;
    logic [7:0]              res_hi;
    logic [7:0]              res_lo;
    logic [7:0]              ctrl0;
    logic [7:0]              pincfg;
    logic [7:0]              timing;
    logic [3:0]              cmp_mode;
    logic                    flag;
    logic [4:0]              tads;
    logic [1:0]              dly;
    logic [9:0]              sar;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    sample;
    logic                    conv;
    logic                    bstrobe;
    logic                    tclr;
  } seq_s;

  seq_s        s_r;
  seq_s        s_nxt;
  logic        tick;
  logic        setup;
  logic        wr;
  logic        hit;
  logic        wr_ctrl0;
  logic        sw_stop;
  logic        sw_abort;
  logic        busy;
  logic        en;
  logic        go;
  logic        trig;
  logic [2:0]  acq_sel;
  logic [4:0]  acq_last;
  logic [31:0] rd_val;
  logic [9:0]  sar_new;
  logic [3:0]  bit_idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Bit-period tick, runs while the converter is enabled
  tad_divider u_div (
    .clk       (clk),
    .rstn      (rstn),
    .run       (en),
    .clk_sel   (s_r.timing[adc_seq_pkg::TIM_CLKSEL_LSB +: 3]),
    .rc_strobe (rc_strobe),
    .tick      (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of bus phases and control fields
  assign setup    = psel && !penable;
  assign wr       = psel && penable && s_r.pready && pwrite;
  assign wr_ctrl0 = wr && paddr == adc_seq_pkg::OFS_CONTROL_ZERO;
  assign sw_stop  = wr_ctrl0 && !(pwdata[adc_seq_pkg::CTL_GO_BIT]
                                  && pwdata[adc_seq_pkg::CTL_ENABLE_BIT]);
  assign sw_abort = busy && wr_ctrl0 && !pwdata[adc_seq_pkg::CTL_GO_BIT]
                    && pwdata[adc_seq_pkg::CTL_ENABLE_BIT];
  assign busy     = s_r.st inside {adc_seq_pkg::START_DELAY, adc_seq_pkg::ACQUIRE,
                                   adc_seq_pkg::CONVERT};
  assign en       = s_r.ctrl0[adc_seq_pkg::CTL_ENABLE_BIT];
  assign go       = s_r.ctrl0[adc_seq_pkg::CTL_GO_BIT];
  assign trig     = special_event && s_r.cmp_mode == adc_seq_pkg::CMP_SPECIAL_TRIGGER;
  assign acq_sel  = s_r.timing[adc_seq_pkg::TIM_ACQ_LSB +: 3];
  assign acq_last = adc_seq_pkg::ACQ_TADS[acq_sel] - 5'h01;
  assign bit_idx  = 4'(adc_seq_pkg::CONV_LAST - s_r.tads);

  // Address decode and read mux
  always_comb begin
    hit    = 1'h1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      adc_seq_pkg::OFS_RESULT_HIGH:  rd_val[7:0] = s_r.res_hi;
      adc_seq_pkg::OFS_RESULT_LOW:   rd_val[7:0] = s_r.res_lo;
      adc_seq_pkg::OFS_CONTROL_ZERO: rd_val[7:0] = s_r.ctrl0;
      adc_seq_pkg::OFS_PIN_CONFIG:   rd_val[7:0] = s_r.pincfg;
      adc_seq_pkg::OFS_TIMING:       rd_val[7:0] = s_r.timing;
      adc_seq_pkg::OFS_PORT_READ:    rd_val[6:0] = pin_in & s_r.pincfg[6:0];
      adc_seq_pkg::OFS_TRIGGER:      rd_val[4:0] = {s_r.flag, s_r.cmp_mode};
      default:                       hit = 1'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: bus, register writes, sequencer, trigger
  always_comb begin
    s_nxt         = s_r;
    s_nxt.bstrobe = 1'h0;
    s_nxt.tclr    = 1'h0;
    sar_new       = s_r.sar;
    // Answer one cycle after setup; read data captured in the setup cycle
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && !hit;
    if (setup && !pwrite) begin
      s_nxt.prdata = hit ? rd_val : 32'h0000_0000;
    end
    // Software writes, taken at the access edge
    if (wr) begin
      unique case (paddr)
        adc_seq_pkg::OFS_RESULT_HIGH:  s_nxt.res_hi = pwdata[7:0];
        adc_seq_pkg::OFS_RESULT_LOW:   s_nxt.res_lo = pwdata[7:0];
        adc_seq_pkg::OFS_CONTROL_ZERO: s_nxt.ctrl0 = pwdata[7:0] & adc_seq_pkg::CONTROL_ZERO_MSK;
        adc_seq_pkg::OFS_PIN_CONFIG:   s_nxt.pincfg = pwdata[7:0] & adc_seq_pkg::PIN_CONFIG_MSK;
        adc_seq_pkg::OFS_TIMING:       s_nxt.timing = pwdata[7:0] & adc_seq_pkg::TIMING_MSK;
        adc_seq_pkg::OFS_TRIGGER: begin
          s_nxt.cmp_mode = pwdata[3:0];
          s_nxt.flag     = s_r.flag && pwdata[adc_seq_pkg::TRG_FLAG_BIT];
        end
        default: s_nxt.res_hi = s_r.res_hi;
      endcase
    end
    // Sequencer; channel and pin bits take no part in it
    unique case (s_r.st)
      adc_seq_pkg::SAMPLE: begin
        if (go && en) begin
          s_nxt.tads = 5'h00;
          s_nxt.dly  = 2'h0;
          s_nxt.st   = (acq_sel == 3'h0) ? adc_seq_pkg::START_DELAY
                                         : adc_seq_pkg::ACQUIRE;
        end
      end
      adc_seq_pkg::START_DELAY: begin
        if (s_r.dly == adc_seq_pkg::INSTR_LAST) begin
          s_nxt.st   = adc_seq_pkg::CONVERT;
          s_nxt.tads = 5'h00;
          s_nxt.sar  = 10'h000;
        end else begin
          s_nxt.dly = s_r.dly + 2'h1;
        end
      end
      adc_seq_pkg::ACQUIRE: begin
        if (tick) begin
          if (s_r.tads == acq_last) begin
            s_nxt.st   = adc_seq_pkg::CONVERT;
            s_nxt.tads = 5'h00;
            s_nxt.sar  = 10'h000;
          end else begin
            s_nxt.tads = s_r.tads + 5'h01;
          end
        end
      end
      adc_seq_pkg::CONVERT: begin
        if (tick) begin
          if (s_r.tads != 5'h00) begin
            sar_new[bit_idx] = comp_bit;
            s_nxt.sar        = sar_new;
            s_nxt.bstrobe    = 1'h1;
          end
          if (s_r.tads == adc_seq_pkg::CONV_LAST && !sw_stop) begin
            // Completion unless a stop lands on the last tick: store, drop start, flag
            if (s_r.timing[adc_seq_pkg::TIM_FORMAT_BIT]) begin
              s_nxt.res_hi = {6'h00, sar_new[9:8]};
              s_nxt.res_lo = sar_new[7:0];
            end else begin
              s_nxt.res_hi = sar_new[9:2];
              s_nxt.res_lo = {sar_new[1:0], 6'h00};
            end
            s_nxt.ctrl0[adc_seq_pkg::CTL_GO_BIT] = 1'h0;
            s_nxt.flag = 1'h1;
            s_nxt.st   = adc_seq_pkg::RECOVER;
            s_nxt.tads = 5'h00;
          end else begin
            s_nxt.tads = s_r.tads + 5'h01;
          end
        end
      end
      adc_seq_pkg::RECOVER: begin
        if (tick) begin
          if (s_r.tads == adc_seq_pkg::RECOVER_LAST) begin
            s_nxt.st = adc_seq_pkg::SAMPLE;
          end else begin
            s_nxt.tads = s_r.tads + 5'h01;
          end
        end
      end
      default: s_nxt.st = adc_seq_pkg::SAMPLE;
    endcase
    // Software abort: partial result dropped, result bytes untouched
    if (busy && !s_nxt.ctrl0[adc_seq_pkg::CTL_GO_BIT]) begin
      s_nxt.st   = adc_seq_pkg::RECOVER;
      s_nxt.tads = 5'h00;
    end
    // Disabled converter holds start/done low and idles
    if (!s_nxt.ctrl0[adc_seq_pkg::CTL_ENABLE_BIT]) begin
      s_nxt.ctrl0[adc_seq_pkg::CTL_GO_BIT] = 1'h0;
      s_nxt.st = adc_seq_pkg::SAMPLE;
    end
    // Special event trigger; its set wins over any clear while the converter stays enabled
    if (trig) begin
      s_nxt.tclr = 1'h1;
      if (s_nxt.ctrl0[adc_seq_pkg::CTL_ENABLE_BIT]) begin
        s_nxt.ctrl0[adc_seq_pkg::CTL_GO_BIT] = 1'h1;
      end
    end
    s_nxt.sample = s_nxt.ctrl0[adc_seq_pkg::CTL_ENABLE_BIT]
                   && s_nxt.st inside {adc_seq_pkg::SAMPLE, adc_seq_pkg::START_DELAY,
                                       adc_seq_pkg::ACQUIRE};
    s_nxt.conv   = s_nxt.st == adc_seq_pkg::CONVERT;
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r          <= '0;
      s_r.st       <= adc_seq_pkg::SAMPLE;
      s_r.res_hi   <= adc_seq_pkg::RESULT_RST;
      s_r.res_lo   <= adc_seq_pkg::RESULT_RST;
      s_r.ctrl0    <= adc_seq_pkg::CONTROL_ZERO_RST;
      s_r.pincfg   <= adc_seq_pkg::PIN_CONFIG_RST;
      s_r.timing   <= adc_seq_pkg::TIMING_RST;
      s_r.cmp_mode <= adc_seq_pkg::CMP_MODE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register
  assign prdata        = s_r.prdata;
  assign pready        = s_r.pready;
  assign pslverr       = s_r.pslverr;
  assign sample_en     = s_r.sample;
  assign conv_active   = s_r.conv;
  assign bit_strobe    = s_r.bstrobe;
  assign channel       = s_r.ctrl0[adc_seq_pkg::CTL_CHAN_LSB +: 3];
  assign ref_pos_sel   = s_r.ctrl0[adc_seq_pkg::CTL_VPOS_BIT];
  assign ref_neg_sel   = s_r.ctrl0[adc_seq_pkg::CTL_VNEG_BIT];
  assign timer_clear   = s_r.tclr;
  assign complete_flag = s_r.flag;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  conv_bound_a : assert property (@(posedge clk) disable iff (!rstn)
    (s_r.st == adc_seq_pkg::CONVERT) |-> (s_r.tads <= 5'h0A))
    else $error("conversion ran past eleven bit periods");

  done_flag_a : assert property (@(posedge clk) disable iff (!rstn)
    (s_r.st == adc_seq_pkg::CONVERT && tick && s_r.tads == 5'h0A && !sw_stop && !trig)
      |=> (s_r.st == adc_seq_pkg::RECOVER && !go && s_r.flag && !conv_active))
    else $error("completion did not clear start or set flag");

  acq_four_a : assert property (@(posedge clk) disable iff (!rstn)
    (s_r.st == adc_seq_pkg::ACQUIRE && acq_sel == 3'h2 && tick && s_r.tads == 5'h03
      && !sw_stop) |=> (s_r.st == adc_seq_pkg::CONVERT && s_r.tads == 5'h00))
    else $error("four period acquisition did not end in conversion");

  sleep_delay_a : assert property (@(posedge clk) disable iff (!rstn)
    (s_r.st == adc_seq_pkg::SAMPLE && go && en && acq_sel == 3'h0 && !sw_stop)
      ##1 (!sw_stop && s_r.st == adc_seq_pkg::START_DELAY)[*4]
      |=> (s_r.st == adc_seq_pkg::CONVERT))
    else $error("instruction cycle delay not four clocks");

  abort_keep_a : assert property (@(posedge clk) disable iff (!rstn)
    sw_abort |=> (s_r.st == adc_seq_pkg::RECOVER && $stable(s_r.res_hi)
                  && $stable(s_r.res_lo) && !conv_active))
    else $error("abort did not stop or kept no old result");

  recovery_a : assert property (@(posedge clk) disable iff (!rstn)
    (s_r.st == adc_seq_pkg::RECOVER && tick && s_r.tads == 5'h01 && !sw_stop)
      |=> (s_r.st == adc_seq_pkg::SAMPLE && sample_en))
    else $error("sampling not resumed after two periods");

  trig_start_a : assert property (@(posedge clk) disable iff (!rstn)
    (trig && en && !wr_ctrl0) |=> (go && timer_clear))
    else $error("special event did not start conversion");

  trig_ignore_a : assert property (@(posedge clk) disable iff (!rstn)
    (trig && !en && !wr_ctrl0) |=> (!go && timer_clear && s_r.st == adc_seq_pkg::SAMPLE))
    else $error("disabled converter reacted to special event");

  port_mask_a : assert property (@(posedge clk) disable iff (!rstn)
    (setup && !pwrite && paddr == adc_seq_pkg::OFS_PORT_READ)
      |=> ((prdata[6:0] & ~s_r.pincfg[6:0]) == 7'h00 && prdata[31:7] == 25'h0))
    else $error("analog pin read back nonzero");

endmodule : adc_sequencer

// >>> pkg/adc_seq_pkg.sv
// Register map, field positions, reset values and sequencing constants of the converter
package adc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the APB port
  localparam logic [7:0] OFS_RESULT_HIGH  = 8'h00;
  localparam logic [7:0] OFS_RESULT_LOW   = 8'h04;
  localparam logic [7:0] OFS_CONTROL_ZERO = 8'h08;
  localparam logic [7:0] OFS_PIN_CONFIG   = 8'h0C;
  localparam logic [7:0] OFS_TIMING       = 8'h10;
  localparam logic [7:0] OFS_PORT_READ    = 8'h14;
  localparam logic [7:0] OFS_TRIGGER      = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and writable-bit masks
  localparam logic [7:0] RESULT_RST       = 8'h00;
  localparam logic [7:0] CONTROL_ZERO_RST = 8'h00;
  localparam logic [7:0] PIN_CONFIG_RST   = 8'h00;
  localparam logic [7:0] TIMING_RST       = 8'h00;
  localparam logic [3:0] CMP_MODE_RST     = 4'h0;
  localparam logic [7:0] CONTROL_ZERO_MSK = 8'hDF;
  localparam logic [7:0] PIN_CONFIG_MSK   = 8'h7F;
  localparam logic [7:0] TIMING_MSK       = 8'hBF;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTL_ENABLE_BIT  = 0;
  localparam int CTL_GO_BIT      = 1;
  localparam int CTL_CHAN_LSB    = 2;
  localparam int CTL_VPOS_BIT    = 6;
  localparam int CTL_VNEG_BIT    = 7;
  localparam int TIM_CLKSEL_LSB  = 0;
  localparam int TIM_ACQ_LSB     = 3;
  localparam int TIM_FORMAT_BIT  = 7;
  localparam int TRG_FLAG_BIT    = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing constants
  localparam logic [3:0] CMP_SPECIAL_TRIGGER = 4'hB;
  localparam logic [1:0] CLK_RC_CODE         = 2'h3;
  localparam logic [4:0] CONV_LAST           = 5'h0A;  // Eleven bit periods, 0..10
  localparam logic [4:0] RECOVER_LAST        = 5'h01;  // Two bit periods, 0..1
  localparam logic [1:0] INSTR_LAST          = 2'h3;   // One instruction cycle of four clocks
  // Acquisition length in bit periods, indexed by acquisition_time_select
  localparam logic [7:0][4:0] ACQ_TADS = {5'h14, 5'h10, 5'h0C, 5'h08,
                                         5'h06, 5'h04, 5'h02, 5'h00};

  typedef enum logic [2:0] {SAMPLE, START_DELAY, ACQUIRE, CONVERT, RECOVER} seq_state_e;

endpackage : adc_seq_pkg

// >>> logic/tad_divider.sv
// Bit-period tick generator: divides the clock or passes the RC strobe
`timescale 1ns/10ps
module tad_divider (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  input  wire logic       rc_strobe,
  output logic            tick
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } div_s;

  div_s       s_r;
  div_s       s_nxt;
  logic       rc_mode;
  logic [5:0] last;

  ////////////////////////////////////////////////////////////////////////////////
  // Ratio is 2 << {sel[1:0], sel[2]}: 000=2 100=4 001=8 101=16 010=32 110=64
  assign rc_mode = clk_sel[1:0] == adc_seq_pkg::CLK_RC_CODE;
  assign last    = 6'((7'h02 << {clk_sel[1:0], clk_sel[2]}) - 7'h01);

  // Count clocks, or forward the RC strobe
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'h0;
    if (!run) begin
      s_nxt.cnt = 6'h00;
    end else if (rc_mode) begin
      s_nxt.cnt  = 6'h00;
      s_nxt.tick = rc_strobe;
    end else if (s_r.cnt >= last) begin
      s_nxt.cnt  = 6'h00;
      s_nxt.tick = 1'h1;
    end else begin
      s_nxt.cnt = s_r.cnt + 6'h01;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Divide-by-two spacing of ticks and forwarding of the RC strobe
  div_two_a : assert property (@(posedge clk) disable iff (!rstn)
    (tick && run && clk_sel == 3'h0) ##1 (run && clk_sel == 3'h0)
      |=> (tick && !$past(tick)))
    else $error("divide-by-two tick spacing wrong");

  rc_pass_a : assert property (@(posedge clk) disable iff (!rstn)
    (run && rc_mode && rc_strobe) |=> tick)
    else $error("RC strobe not forwarded as tick");

endmodule : tad_divider

// >>> tb/adc_analog_model.sv
// Behavioural analog front end: comparator decisions and the RC bit-period strobe
`timescale 1ns/10ps
module adc_analog_model #(
  parameter int RC_PER = 6
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       conv_active,
  input  wire logic       bit_strobe,
  input  wire logic [9:0] level,
  output logic            comp_bit,
  output logic            rc_strobe
);
  int   idx;
  int   rc_cnt;
  logic junk;

  ////////////////////////////////////////////////////////////////////////////////
  // Decision index advances after each capture; RC source runs free
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx <= 0;
      rc_cnt <= 0;
      junk <= 1'h0;
    end else begin
      junk <= ~junk;
      rc_cnt <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
      if (!conv_active) begin
        idx <= 0;
      end else if (bit_strobe) begin
        idx <= idx + 1;
      end
    end
  end

  // Outside a conversion the comparator output is meaningless, so it toggles
  assign comp_bit  = (conv_active && idx < 10) ? level[9 - idx] : junk;
  assign rc_strobe = (rc_cnt == 0);
endmodule : adc_analog_model

// >>> tb/adc_conversion_sequencer_test.sv
// Self-checking bench for the converter sequencer with a result model
`timescale 1ns/10ps
module adc_conversion_sequencer_test;
  localparam int RC_PER = 6;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rc_strobe, comp_bit;
  logic        special_event, sample_en, conv_active, bit_strobe;
  logic        ref_pos_sel, ref_neg_sel, timer_clear, complete_flag, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0]  pin_in, cfg;
  logic [2:0]  channel, chan;
  logic [9:0]  level;
  logic [7:0]  exp_hi, exp_lo;
  int          err_total, n_checks, i, gap, len, rec;
  logic [2:0]  cs_tab [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int          d_tab [7] = '{2, 4, 8, 16, 32, 64, RC_PER};
  int          acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  adc_sequencer uut (.*);
  adc_analog_model #(.RC_PER(RC_PER)) analog (.*);

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // One APB transfer, then an idle cycle so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      chk("apb_wait", 32'h0, 32'h1);
      print_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, q, exp);
  endtask : rdc

  // Bounded wait on conversion (k=0) or sampling (k=1) reaching a level
  task automatic wait_lvl(input int k, input logic lvl, output int cyc);
    cyc = 0;
    while (((k == 0) ? conv_active : sample_en) !== lvl && cyc < 5000) begin
      @(posedge clk);
      cyc++;
    end
    if (cyc >= 5000) begin
      chk("wait", 32'h0, 32'h1);
      print_verdict();
    end
  endtask : wait_lvl

  // Compare-unit event pulse, then a check of timer clear against the expected level
  task automatic pulse(input logic exp);
    special_event <= 1'h1;
    @(posedge clk);
    special_event <= 1'h0;
    @(posedge clk);
    chk("timer_clear", 32'(timer_clear), 32'(exp));
  endtask : pulse

  // Full conversion with timing, result and handshake checks
  task automatic run_conv(input logic [2:0] cs, input logic [2:0] acq, input int d);
    logic       fmt;
    int         n;
    logic [1:0] refs;
    fmt = 1'($urandom);
    chan = 3'($urandom);
    level = 10'($urandom);
    refs = 2'($urandom);
    n = acq_tab[acq];
    apb(1'h1, adc_seq_pkg::OFS_TIMING, {24'h0, fmt, 1'h0, acq, cs});
    apb(1'h1, adc_seq_pkg::OFS_CONTROL_ZERO, {24'h0, refs, 1'h0, chan, 2'h1});
    apb(1'h1, adc_seq_pkg::OFS_CONTROL_ZERO, {24'h0, refs, 1'h0, chan, 2'h3});
    wait_lvl(0, 1'h1, gap);
    if (acq == 3'h0) begin
      chk("start_delay", 32'(gap >= 2 && gap <= 6), 32'h1);
    end else begin
      chk("acq_len", 32'(gap >= (n - 1) * d && gap <= n * d + 2), 32'h1);
    end
    wait_lvl(0, 1'h0, len);
    if (acq != 3'h0) begin
      chk("conv_len", 32'(len), 32'(11 * d));
    end else begin
      chk("conv_len", 32'(len > 10 * d && len <= 11 * d), 32'h1);
    end
    wait_lvl(1, 1'h1, rec);
    chk("recover", 32'(rec >= 2 * d - 1 && rec <= 2 * d + 1), 32'h1);
    exp_hi = fmt ? {6'h00, level[9:8]} : level[9:2];
    exp_lo = fmt ? level[7:0] : {level[1:0], 6'h00};
    chk("channel", 32'(channel), 32'(chan));
    chk("ref_sel", 32'({ref_neg_sel, ref_pos_sel}), 32'(refs));
    chk("flag", 32'(complete_flag), 32'h1);
    rdc("ctrl_done", adc_seq_pkg::OFS_CONTROL_ZERO, {24'h0, refs, 1'h0, chan, 2'h1});
    rdc("res_hi", adc_seq_pkg::OFS_RESULT_HIGH, 32'(exp_hi));
    rdc("res_lo", adc_seq_pkg::OFS_RESULT_LOW, 32'(exp_lo));
    apb(1'h1, adc_seq_pkg::OFS_TRIGGER, 32'h0);
    chk("flag_clr", 32'(complete_flag), 32'h0);
  endtask : run_conv

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 250 MHz
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Main sequence
  initial begin
    {rstn, psel, penable, pwrite, special_event} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_in = 7'h00;
    level = 10'h000;
    err_total = 0;
    n_checks = 0;
    void'($urandom(91));
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rdc("ctrl0_rst", adc_seq_pkg::OFS_CONTROL_ZERO, 32'h0);
    rdc("timing_rst", adc_seq_pkg::OFS_TIMING, 32'h0);
    rdc("unmapped", 8'h1C, 32'h0);
    chk("slverr", 32'(e), 32'h1);
    for (i = 0; i < 4; i++) begin
      pin_in <= 7'($urandom);
      cfg = 7'($urandom);
      apb(1'h1, adc_seq_pkg::OFS_PIN_CONFIG, 32'(cfg));
      rdc("port_read", adc_seq_pkg::OFS_PORT_READ, 32'(pin_in & cfg));
    end
    // Last entry selects the RC source, as sleep and slow clocks require
    for (i = 0; i < 7; i++) begin
      run_conv(cs_tab[i], 3'h2, d_tab[i]);
    end
    // Shortest bit period for the acquisition sweep
    for (i = 0; i < 8; i++) begin
      run_conv(3'h0, 3'(i), 2);
    end
    // Abort keeps the software-written result
    apb(1'h1, adc_seq_pkg::OFS_RESULT_HIGH, 32'h000000A5);
    apb(1'h1, adc_seq_pkg::OFS_RESULT_LOW, 32'h0000003C);
    apb(1'h1, adc_seq_pkg::OFS_TIMING, 32'h00000015);
    apb(1'h1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h00000001);
    apb(1'h1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h00000003);
    wait_lvl(0, 1'h1, gap);
    repeat (40) @(posedge clk);
    apb(1'h1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h00000001);
    @(posedge clk);
    chk("abort", 32'(conv_active), 32'h0);
    wait_lvl(1, 1'h1, rec);
    chk("abort_wait", 32'(rec >= 14 && rec <= 33), 32'h1);
    rdc("keep_hi", adc_seq_pkg::OFS_RESULT_HIGH, 32'h000000A5);
    rdc("keep_lo", adc_seq_pkg::OFS_RESULT_LOW, 32'h0000003C);
    chk("abort_flag", 32'(complete_flag), 32'h0);
    // Compare-unit trigger while disabled, enabled, and in another mode
    apb(1'h1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h0);
    apb(1'h1, adc_seq_pkg::OFS_TRIGGER, 32'h0000000B);
    pulse(1'h1);
    rdc("trig_off", adc_seq_pkg::OFS_CONTROL_ZERO, 32'h0);
    apb(1'h1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h00000001);
    pulse(1'h1);
    wait_lvl(0, 1'h1, gap);
    wait_lvl(0, 1'h0, len);
    chk("trig_len", 32'(len), 32'(11 * 16));
    rdc("trig_hi", adc_seq_pkg::OFS_RESULT_HIGH, 32'(level[9:2]));
    rdc("trig_reg", adc_seq_pkg::OFS_TRIGGER, 32'h0000001B);
    apb(1'h1, adc_seq_pkg::OFS_TRIGGER, 32'h0000000A);
    pulse(1'h0);
    print_verdict();
  end
endmodule : adc_conversion_sequencer_test
